// ===== hdl/lds_pkg.sv
// Constants and types for the lock detect filter and status output selector
package lds_pkg;
    localparam int unsigned PCLK_NS    = 100;
    localparam int unsigned NARROW_NS  = 15;
    localparam int unsigned WIDE_NS    = 30;
    localparam int unsigned NARROW_CYC = (NARROW_NS / PCLK_NS < 1) ? 1 : NARROW_NS / PCLK_NS;
    localparam int unsigned WIDE_CYC   = (WIDE_NS / PCLK_NS < 1) ? 1 : WIDE_NS / PCLK_NS;
    localparam int unsigned LOCK_RUN   = 4;
    localparam int unsigned WORD_W     = 18;
    localparam int unsigned SEL_HI     = 17;
    localparam int unsigned SEL_LO     = 14;
    localparam int unsigned MPOL_BIT   = 14;
    localparam int unsigned APOL_BIT   = 15;
    localparam int unsigned EV_W       = 5;
    localparam int unsigned STATE_W    = 10;
    localparam logic [1:0]  CTL_MAIN_R = 2'h0;
    localparam logic [1:0]  CTL_AUX_R  = 2'h1;
    localparam logic [3:0]  SEL_LOW    = 4'h0;
    localparam logic [3:0]  SEL_HIGH   = 4'h1;
    localparam logic [2:0]  GRP_FIXED  = 3'h0;
    localparam logic [2:0]  GRP_MLD    = 3'h1;
    localparam logic [2:0]  GRP_ALD    = 3'h2;
    localparam logic [2:0]  GRP_BLD    = 3'h3;
    localparam logic [2:0]  GRP_MREF   = 3'h4;
    localparam logic [2:0]  GRP_AREF   = 3'h5;
    localparam logic [2:0]  GRP_MFB    = 3'h6;
    localparam logic [2:0]  GRP_AFB    = 3'h7;
    localparam logic [7:0]  OFS_STATUS = 8'h00;
    localparam logic [7:0]  OFS_MASK   = 8'h04;
    localparam logic [7:0]  OFS_CTRL   = 8'h08;
    localparam logic [7:0]  OFS_STATE  = 8'h0C;
    localparam logic [7:0]  OFS_MAIN_R = 8'h10;
    localparam logic [7:0]  OFS_AUX_R  = 8'h14;
    localparam logic [17:0] WORD_RST   = 18'h00000;
    localparam logic [4:0]  EV_RST     = 5'h00;
    localparam logic [1:0]  CTRL_RST   = 2'h0;

    typedef enum logic {FLT_HUNT, FLT_LOCKED} lds_flt_e;

    typedef struct packed {
        logic       ser_clk;
        logic       ser_data;
        logic       strobe;
        logic [1:0] ref_in;
        logic [1:0] fb_in;
        logic [1:0] pd;
    } lds_pins_s;

    typedef struct packed {
        logic [3:0] sel;
        logic [1:0] pol;
    } lds_cfg_s;
endpackage : lds_pkg

// ===== hdl/lds_top.sv
// Lock detect filters, phase detectors, serial port and status output selector
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
module lds_top
    import lds_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = LOCK_RUN,
    parameter int unsigned ERR_W       = 4
)(
    input  logic        pclk,
    input  logic        presetn,
    input  logic [7:0]  paddr,
    input  logic        psel,
    input  logic        penable,
    input  logic        pwrite,
    input  logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    input  logic        ser_clk,
    input  logic        ser_data,
    input  logic        latch_strobe,
    input  logic [1:0]  reference_compare_input,
    input  logic [1:0]  feedback_compare_input,
    input  logic [1:0]  loop_powerdown,
    output logic        status_pin,
    output logic        osc_crystal_mode,
    output logic [1:0]  pump_up,
    output logic [1:0]  pump_down,
    output logic        irq
);
    localparam logic [ERR_W-1:0] ERR_MAX  = '1;
    localparam logic [ERR_W-1:0] NARROW_C = ERR_W'(NARROW_CYC);
    localparam logic [ERR_W-1:0] WIDE_C   = ERR_W'(WIDE_CYC);
    localparam logic [2:0]       RUN_LAST = 3'(LOCK_CYCLES - 1);

    if (LOCK_CYCLES < 1 || LOCK_CYCLES > 8 || WIDE_CYC >= (2 ** ERR_W) - 1) begin : g_bad
        $error("lds_top: unsupported parameters");
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    lds_pins_s          pin_in;
    lds_pins_s          pin_meta_reg;
    lds_pins_s          pin_sync_reg;
    lds_pins_s          pin_last_reg;
    lds_cfg_s           cfg;
    logic [WORD_W-1:0]  shift_reg;
    logic [WORD_W-1:0]  main_r_reg;
    logic [WORD_W-1:0]  aux_r_reg;
    logic               ser_rise;
    logic               le_rise;
    logic               data_s;
    logic [1:0]         ref_s;
    logic [1:0]         fb_s;
    logic               up_reg [2];
    logic               dn_reg [2];
    logic [ERR_W-1:0]   err_reg [2];
    lds_flt_e           flt_reg [2];
    logic [2:0]         run_reg [2];
    logic               lock_reg [2];
    logic               lock_prev_reg [2];
    logic               pump_up_reg [2];
    logic               pump_dn_reg [2];
    logic               status_pin_reg;
    logic               osc_reg;
    logic [EV_W-1:0]    status_reg;
    logic [EV_W-1:0]    status_next;
    logic [EV_W-1:0]    mask_reg;
    logic [EV_W-1:0]    ev;
    logic [1:0]         ctrl_reg;
    logic               irq_reg;
    logic               pready_reg;
    logic               pslverr_reg;
    logic [31:0]        prdata_reg;
    logic [31:0]        rd_data;
    logic               rd_hit;
    logic               setup;
    logic               wr;

    assign pin_in = {ser_clk, ser_data, latch_strobe, reference_compare_input,
                     feedback_compare_input, loop_powerdown};

    // Pins are asynchronous to pclk; the second stage is used, and the third only as edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
            pin_last_reg <= '0;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
            pin_last_reg <= pin_sync_reg;
        end
    end

    assign ser_rise = pin_sync_reg.ser_clk & ~pin_last_reg.ser_clk;
    assign le_rise  = pin_sync_reg.strobe & ~pin_last_reg.strobe;
    assign data_s   = pin_sync_reg.ser_data;
    assign ref_s    = pin_sync_reg.ref_in;
    assign fb_s     = pin_sync_reg.fb_in;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg <= WORD_RST;
        end else if (ser_rise) begin
            shift_reg <= {shift_reg[WORD_W-2:0], data_s};
        end
    end

    // Other latch codes belong to divider words held elsewhere
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_r_reg <= WORD_RST;
            aux_r_reg  <= WORD_RST;
        end else if (le_rise) begin
            if (shift_reg[1:0] == CTL_MAIN_R) begin
                main_r_reg <= shift_reg;
            end
            if (shift_reg[1:0] == CTL_AUX_R) begin
                aux_r_reg <= shift_reg;
            end
        end
    end

    assign cfg.sel = aux_r_reg[SEL_HI:SEL_LO];
    assign cfg.pol = {main_r_reg[APOL_BIT], main_r_reg[MPOL_BIT]};

    for (genvar i = 0; i < 2; i++) begin : g_loop
        logic ref_rise;
        logic fb_rise;
        logic pd;
        logic both;
        logic stale;
        logic in_narrow;
        logic out_wide;

        assign ref_rise  = ref_s[i] & ~pin_last_reg.ref_in[i];
        assign fb_rise   = fb_s[i] & ~pin_last_reg.fb_in[i];
        assign pd        = pin_sync_reg.pd[i] | ctrl_reg[i];
        assign both      = up_reg[i] & dn_reg[i];
        // A second edge on one side before the other is a slip past a full cycle
        assign stale     = (ref_rise & up_reg[i] & ~dn_reg[i])
                         | (fb_rise & dn_reg[i] & ~up_reg[i]);
        assign in_narrow = both & (err_reg[i] < NARROW_C);
        assign out_wide  = (both & (err_reg[i] > WIDE_C)) | stale;

        // Either input may lead, so the detector spans a full two-pi each way
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                up_reg[i] <= 1'b0;
                dn_reg[i] <= 1'b0;
            end else if (pd || both) begin
                up_reg[i] <= 1'b0;
                dn_reg[i] <= 1'b0;
            end else begin
                up_reg[i] <= up_reg[i] | ref_rise;
                dn_reg[i] <= dn_reg[i] | fb_rise;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                err_reg[i] <= '0;
            end else if (pd || both) begin
                err_reg[i] <= '0;
            end else if ((up_reg[i] ^ dn_reg[i]) && err_reg[i] != ERR_MAX) begin
                err_reg[i] <= err_reg[i] + 1'b1;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pump_up_reg[i] <= 1'b0;
                pump_dn_reg[i] <= 1'b0;
            end else begin
                pump_up_reg[i] <= cfg.pol[i] ? up_reg[i] : dn_reg[i];
                pump_dn_reg[i] <= cfg.pol[i] ? dn_reg[i] : up_reg[i];
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                flt_reg[i]  <= FLT_HUNT;
                run_reg[i]  <= 3'h0;
                lock_reg[i] <= 1'b0;
            end else if (pd) begin
                flt_reg[i]  <= FLT_HUNT;
                run_reg[i]  <= 3'h0;
                lock_reg[i] <= 1'b0;
            end else begin
                case (flt_reg[i])
                    FLT_HUNT: begin
                        if (in_narrow) begin
                            if (run_reg[i] == RUN_LAST) begin
                                flt_reg[i]  <= FLT_LOCKED;
                                lock_reg[i] <= 1'b1;
                                run_reg[i]  <= 3'h0;
                            end else begin
                                run_reg[i] <= run_reg[i] + 3'h1;
                            end
                        end else if (both || stale) begin
                            run_reg[i] <= 3'h0;
                        end
                    end
                    FLT_LOCKED: begin
                        if (out_wide) begin
                            flt_reg[i]  <= FLT_HUNT;
                            lock_reg[i] <= 1'b0;
                            run_reg[i]  <= 3'h0;
                        end
                    end
                    default: begin
                        flt_reg[i]  <= FLT_HUNT;
                        lock_reg[i] <= 1'b0;
                        run_reg[i]  <= 3'h0;
                    end
                endcase
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lock_prev_reg[i] <= 1'b0;
            end else begin
                lock_prev_reg[i] <= lock_reg[i];
            end
        end

        property p_lock_entry;
            !lock_reg[i] ##1 lock_reg[i] |-> $past(in_narrow) && $past(run_reg[i]) == RUN_LAST;
        endproperty
        a_lock_entry: assert property (p_lock_entry) else $error("lock without full run");

        property p_lock_exit;
            lock_reg[i] && out_wide |=> !lock_reg[i];
        endproperty
        a_lock_exit: assert property (p_lock_exit) else $error("lock kept past window");

        property p_pd;
            pd |=> !lock_reg[i] && run_reg[i] == 3'h0;
        endproperty
        a_pd: assert property (p_pd) else $error("lock while powered down");

        sequence s_both;
            both ##1 !up_reg[i] && !dn_reg[i];
        endsequence
        property p_pfd;
            both |-> s_both;
        endproperty
        a_pfd: assert property (p_pfd) else $error("pump pulses not released");

        property p_pol;
            1'b1 |=> pump_up_reg[i] == ($past(cfg.pol[i]) ? $past(up_reg[i]) : $past(dn_reg[i]));
        endproperty
        a_pol: assert property (p_pol) else $error("pump polarity wrong");

        property p_miss;
            flt_reg[i] == FLT_HUNT && stale |=> run_reg[i] == 3'h0;
        endproperty
        a_miss: assert property (p_miss) else $error("run kept after miss");

        property p_relock;
            lock_reg[i] ##1 !lock_reg[i] |-> run_reg[i] == 3'h0 && flt_reg[i] == FLT_HUNT;
        endproperty
        a_relock: assert property (p_relock) else $error("no fresh run after unlock");
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_pin_reg <= 1'b0;
        end else begin
            case (cfg.sel[3:1])
                GRP_FIXED: status_pin_reg <= cfg.sel[0];
                GRP_MLD:   status_pin_reg <= lock_reg[0];
                GRP_ALD:   status_pin_reg <= lock_reg[1];
                GRP_BLD:   status_pin_reg <= lock_reg[0] & lock_reg[1];
                GRP_MREF:  status_pin_reg <= ref_s[0];
                GRP_AREF:  status_pin_reg <= ref_s[1];
                GRP_MFB:   status_pin_reg <= fb_s[0];
                GRP_AFB:   status_pin_reg <= fb_s[1];
                default:   status_pin_reg <= 1'b0;
            endcase
        end
    end

    // Fixed pin levels leave the oscillator in its safer crystal drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_reg <= 1'b1;
        end else begin
            osc_reg <= (cfg.sel[3:1] == GRP_FIXED) ? 1'b1 : cfg.sel[0];
        end
    end

    assign ev = {le_rise, lock_reg[1] & ~lock_prev_reg[1], lock_prev_reg[1] & ~lock_reg[1],
                 lock_reg[0] & ~lock_prev_reg[0], lock_prev_reg[0] & ~lock_reg[0]};

    assign setup = psel & ~penable;
    assign wr    = psel & penable & pready_reg & pwrite;

    // A new event wins over a write-one clear in the same cycle
    assign status_next = (status_reg & ~((wr && paddr == OFS_STATUS) ?
                          pwdata[EV_W-1:0] : EV_RST)) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= EV_RST;
            irq_reg    <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq_reg    <= |(status_next & mask_reg);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= EV_RST;
            ctrl_reg <= CTRL_RST;
        end else if (wr) begin
            if (paddr == OFS_MASK) begin
                mask_reg <= pwdata[EV_W-1:0];
            end
            if (paddr == OFS_CTRL) begin
                ctrl_reg <= pwdata[1:0];
            end
        end
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = '0;
        case (paddr)
            OFS_STATUS: rd_data[EV_W-1:0]    = status_reg;
            OFS_MASK:   rd_data[EV_W-1:0]    = mask_reg;
            OFS_CTRL:   rd_data[1:0]         = ctrl_reg;
            OFS_STATE:  rd_data[STATE_W-1:0] = {osc_reg, status_pin_reg, cfg.pol, cfg.sel,
                                                lock_reg[1], lock_reg[0]};
            OFS_MAIN_R: rd_data[WORD_W-1:0]  = main_r_reg;
            OFS_AUX_R:  rd_data[WORD_W-1:0]  = aux_r_reg;
            default:    rd_hit               = 1'b0;
        endcase
    end

    // Answer is prepared in setup so every bus output is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup & ~rd_hit;
            prdata_reg  <= setup ? rd_data : '0;
        end
    end

    assign prdata           = prdata_reg;
    assign pready           = pready_reg;
    assign pslverr          = pslverr_reg;
    assign status_pin       = status_pin_reg;
    assign osc_crystal_mode = osc_reg;
    assign pump_up          = {pump_up_reg[1], pump_up_reg[0]};
    assign pump_down        = {pump_dn_reg[1], pump_dn_reg[0]};
    assign irq              = irq_reg;

    property p_fixed_low;
        cfg.sel == SEL_LOW |=> !status_pin_reg;
    endproperty
    a_fixed_low: assert property (p_fixed_low) else $error("pin not low");

    property p_fixed_high;
        cfg.sel == SEL_HIGH |=> status_pin_reg;
    endproperty
    a_fixed_high: assert property (p_fixed_high) else $error("pin not high");

    property p_both_lock;
        cfg.sel[3:1] == GRP_BLD |=> status_pin_reg == ($past(lock_reg[0]) && $past(lock_reg[1]));
    endproperty
    a_both_lock: assert property (p_both_lock) else $error("combined lock wrong");

    property p_aux_ref;
        cfg.sel[3:1] == GRP_AREF |=> status_pin_reg == $past(ref_s[1]);
    endproperty
    a_aux_ref: assert property (p_aux_ref) else $error("aux reference not routed");

    property p_main_fb;
        cfg.sel[3:1] == GRP_MFB |=> status_pin_reg == $past(fb_s[0]);
    endproperty
    a_main_fb: assert property (p_main_fb) else $error("main feedback not routed");

    property p_osc_mode;
        cfg.sel[3:1] != GRP_FIXED |=> osc_reg == $past(aux_r_reg[SEL_LO]);
    endproperty
    a_osc_mode: assert property (p_osc_mode) else $error("oscillator mode wrong");

    property p_osc_forced;
        cfg.sel[3:1] == GRP_FIXED |=> osc_reg;
    endproperty
    a_osc_forced: assert property (p_osc_forced) else $error("crystal mode not forced");

    sequence s_ser_edge;
        ser_rise;
    endsequence
    property p_shift;
        s_ser_edge |=> shift_reg == {$past(shift_reg[WORD_W-2:0]), $past(data_s)};
    endproperty
    a_shift: assert property (p_shift) else $error("serial bit not shifted in");

    property p_latch;
        le_rise && shift_reg[1:0] == CTL_AUX_R |=> aux_r_reg == $past(shift_reg);
    endproperty
    a_latch: assert property (p_latch) else $error("aux word not latched");
endmodule : lds_top

// ===== tb/lds_host.sv
// Host model driving the three-wire serial programming port
`timescale 1ns/1ps
module lds_host (
    input  wire logic pclk,
    output logic      ser_clk,
    output logic      ser_data,
    output logic      latch_strobe
);
    initial begin
        ser_clk      = 1'b0;
        ser_data     = 1'b0;
        latch_strobe = 1'b0;
    end
    // Four pclk per half period gives the 800 ns serial clock
    task automatic half();
        repeat (4) @(posedge pclk);
    endtask : half
    task automatic send(input logic [17:0] word);
        for (int i = 17; i >= 0; i--) begin
            ser_data <= word[i];
            half();
            ser_clk <= 1'b1;
            half();
            ser_clk <= 1'b0;
        end
        // Released line shows the inverse so a stale bit cannot pass
        ser_data <= ~word[0];
        half();
        latch_strobe <= 1'b1;
        half();
        latch_strobe <= 1'b0;
        half();
    endtask : send
endmodule : lds_host

// ===== tb/lds_tb.sv
// Self-checking bench for lock detect filter and status output select
`timescale 1ns/1ps
module tb;
    import lds_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        ser_clk, ser_data, latch_strobe, status_pin, osc_crystal_mode, irq, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  ref_in, fb_in, pd, pump_up, pump_down;
    int          n_fail, n_tests, up_only, dn_only, both_on;

    lds_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .ser_clk, .ser_data, .latch_strobe,
        .reference_compare_input(ref_in), .feedback_compare_input(fb_in),
        .loop_powerdown(pd), .status_pin, .osc_crystal_mode, .pump_up, .pump_down, .irq);
    lds_host host (.pclk, .ser_clk, .ser_data, .latch_strobe);

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Sole writer of the pump counters; scenarios compare against snapshots
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_only <= 0;
            dn_only <= 0;
            both_on <= 0;
        end else begin
            up_only <= up_only + int'(pump_up[0] & ~pump_down[0]);
            dn_only <= dn_only + int'(pump_down[0] & ~pump_up[0]);
            both_on <= both_on + int'(pump_up[0] & pump_down[0]);
        end
    end

    task automatic test_done();
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd & m, e);
    endtask : rdc
    // Main loop edge pair, feedback trailing reference by lag cycles
    // Negative lag sends the reference edge alone
    task automatic pulse(input int lag, input int n);
        repeat (n) begin
            @(posedge pclk);
            ref_in[0] <= 1'b1;
            repeat (lag) @(posedge pclk);
            if (lag >= 0) begin
                fb_in[0] <= 1'b1;
            end
            repeat (6) @(posedge pclk);
            ref_in[0] <= 1'b0;
            fb_in[0]  <= 1'b0;
            repeat (8) @(posedge pclk);
        end
    endtask : pulse

    task automatic t_select();
        logic [7:0] grp_pin;
        grp_pin = 8'h60;
        pd     <= 2'h3;
        ref_in <= 2'h2;
        fb_in  <= 2'h1;
        for (int s = 0; s < 16; s++) begin
            host.send({s[3:0], 12'h000, CTL_AUX_R});
            rdc(OFS_AUX_R, 32'hFFFF_FFFF, {14'h0, s[3:0], 12'h000, 2'h1});
            chk(osc_crystal_mode, (s < 2) ? 1'b1 : s[0]);
            chk(status_pin, (s < 2) ? s[0] : grp_pin[s[3:1]]);
            chk({pump_up, pump_down}, 4'h0);
        end
    endtask : t_select
    task automatic t_irq();
        chk(irq, 1'b0);
        apb(1'b1, OFS_MASK, 32'h0000_0010);
        // Mask lands at the access edge, irq flop follows one edge later
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b1, OFS_STATUS, 32'h0000_001F);
        @(posedge pclk);
        chk(irq, 1'b0);
        rdc(OFS_STATUS, 32'h0000_0010, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0001);
    endtask : t_irq
    task automatic t_lock();
        int u0, d0, b0;
        pd     <= 2'h0;
        ref_in <= 2'h0;
        fb_in  <= 2'h0;
        host.send({4'h2, 12'h000, CTL_AUX_R});
        b0 = both_on;
        pulse(0, 3);
        rdc(OFS_STATE, 32'h0000_0001, 32'h0000_0000);
        pulse(0, 1);
        rdc(OFS_STATE, 32'h0000_0001, 32'h0000_0001);
        chk(status_pin, 1'b1);
        chk(both_on > b0, 1'b1);
        // Combined lock with aux unlocked reads low
        host.send({4'h6, 12'h000, CTL_AUX_R});
        chk(status_pin, 1'b0);
        pulse(1, 1);
        rdc(OFS_STATE, 32'h0000_0001, 32'h0000_0001);
        u0 = up_only;
        d0 = dn_only;
        pulse(3, 1);
        rdc(OFS_STATE, 32'h0000_0001, 32'h0000_0000);
        chk({up_only == u0, dn_only > d0}, 2'h3);
        rdc(OFS_STATUS, 32'h0000_0003, 32'h0000_0003);
        pulse(0, 2);
        pulse(1, 1);
        pulse(0, 3);
        rdc(OFS_STATE, 32'h0000_0001, 32'h0000_0000);
        pulse(0, 1);
        rdc(OFS_STATE, 32'h0000_0001, 32'h0000_0001);
        // Repeated reference edge with no feedback is a cycle slip
        pulse(-1, 2);
        rdc(OFS_STATE, 32'h0000_0001, 32'h0000_0000);
        pulse(0, 5);
        rdc(OFS_STATE, 32'h0000_0001, 32'h0000_0001);
        pd[0] <= 1'b1;
        pulse(0, 1);
        rdc(OFS_STATE, 32'h0000_0001, 32'h0000_0000);
        pd[0] <= 1'b0;
        pulse(0, 4);
        rdc(OFS_STATE, 32'h0000_0001, 32'h0000_0001);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        rdc(OFS_STATE, 32'h0000_0001, 32'h0000_0000);
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        host.send({4'h1, 12'h000, CTL_MAIN_R});
        u0 = up_only;
        d0 = dn_only;
        pulse(3, 1);
        chk({up_only > u0, dn_only == d0}, 2'h3);
    endtask : t_lock

    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr  = 8'h00;
        pwdata = 32'h0000_0000;
        {ref_in, fb_in, pd} = 6'h00;
        {n_fail, n_tests} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({status_pin, osc_crystal_mode, irq}, 3'h2);
        t_select();
        t_irq();
        t_lock();
        test_done();
    end
endmodule : tb
